// ===== core/pdma_regs.svh
// register offsets, field positions and reset values of the peripheral dma unit
`ifndef PDMA_REGS_SVH
`define PDMA_REGS_SVH
`define PDMA_OFF_RX_PTR 12'h100
`define PDMA_OFF_RX_CNT 12'h104
`define PDMA_OFF_TX_PTR 12'h108
`define PDMA_OFF_TX_CNT 12'h10c
`define PDMA_OFF_RX_NPTR 12'h110
`define PDMA_OFF_RX_NCNT 12'h114
`define PDMA_OFF_TX_NPTR 12'h118
`define PDMA_OFF_TX_NCNT 12'h11c
`define PDMA_OFF_CTRL 12'h120
`define PDMA_OFF_STAT 12'h124
`define PDMA_BIT_RX_EN 0
`define PDMA_BIT_RX_DIS 1
`define PDMA_BIT_TX_EN 8
`define PDMA_BIT_TX_DIS 9
`define PDMA_RST_PTR 32'h0000_0000
`define PDMA_RST_CNT 16'h0000
`endif

// ===== core/pdma_pkg.sv
// types of the peripheral dma unit
package pdma_pkg;
    typedef enum logic [1:0] {
        PDMA_IDLE = 2'b00,
        PDMA_RD = 2'b01,
        PDMA_WR = 2'b10
    } pdma_state_e;
    typedef enum logic [1:0] {
        PDMA_SZ_BYTE = 2'b00,
        PDMA_SZ_HALF = 2'b01,
        PDMA_SZ_WORD = 2'b10
    } pdma_size_e;
endpackage

// ===== core/pdma_channel_pair.sv
// receive and transmit dma channel pair serving one serial peripheral
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "pdma_regs.svh"
// Function
// - zero receive count halts receive transfers
// - zero transmit count halts transmit transfers
// - half duplex shares current and next pointers
// - half duplex shares current and next counters
// - receive next pointer and count queued
// - transmit next pointer and count queued
// - bit 0 enables receive unless bit 1
// - bit 1 disables receive requests
// - bits 8/9 enable/disable transmit requests
// - half duplex receive enable disables transmit
// - half duplex transmit enable needs no receive enable
// - half duplex receive disable also disables transmit
// - half duplex transmit disable also disables receive unless bit 0 is written without bit 1
// - status shows receive bit 0, transmit bit 8
// - exhausted current reloads from next, else stops
// - pointer advances by size, count decrements
// - end and buffer flags reported to peripheral
// - nonzero count write clears the flags
module pdma_channel_pair (
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    input wire logic HALF_DUPLEX_I,
    input wire logic [1:0] XFER_SIZE_I,
    input wire logic [11:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    input wire logic RX_READY_I,
    input wire logic TX_READY_I,
    input wire logic [31:0] RX_HOLD_DATA_I,
    output logic RX_HOLD_RD_O,
    output logic [31:0] TX_HOLD_DATA_O,
    output logic TX_HOLD_WR_O,
    output logic BUS_REQ_O,
    input wire logic BUS_GNT_I,
    output logic [31:0] BUS_ADDR_O,
    output logic BUS_WR_O,
    output logic [31:0] BUS_WDATA_O,
    input wire logic [31:0] BUS_RDATA_I,
    input wire logic BUS_DONE_I,
    output logic RX_END_FLAG_O,
    output logic RX_BUFFER_FULL_FLAG_O,
    output logic TX_END_FLAG_O,
    output logic TX_BUFFER_EMPTY_FLAG_O
);
    // ready pins come from the peripheral's own logic on this clock, so no synchroniser
    logic [31:0] rx_ptr_q, tx_ptr_q, rx_nptr_q, tx_nptr_q;
    logic [15:0] rx_cnt_q, tx_cnt_q, rx_ncnt_q, tx_ncnt_q;
    logic rx_en_q, tx_en_q;
    logic rx_end_q, rx_full_q, tx_end_q, tx_empty_q;
    logic [31:0] rdata_q, data_q, addr_q;
    logic dir_tx_q;
    pdma_pkg::pdma_state_e state_q;
    logic step, step_rx, step_tx;
    logic wr_ctrl, rx_en_set, rx_en_clr, tx_en_set, tx_en_clr;
    logic wr_rx_cnt, wr_tx_cnt, wr_rx_ncnt, wr_tx_ncnt, wr_rx_ptr, wr_tx_ptr;
    logic wr_rx_nptr, wr_tx_nptr;
    logic [31:0] eff_rx_ptr, eff_tx_ptr, eff_rx_nptr, eff_tx_nptr;
    logic [15:0] eff_rx_cnt, eff_tx_cnt, eff_rx_ncnt, eff_tx_ncnt;
    logic rx_go, tx_go;

    function automatic logic [31:0] size_step(input logic [1:0] sz);
        case (sz)
            pdma_pkg::PDMA_SZ_HALF: size_step = 32'h0000_0002;
            pdma_pkg::PDMA_SZ_WORD: size_step = 32'h0000_0004;
            default: size_step = 32'h0000_0001;
        endcase
    endfunction

    function automatic logic wr_at(input logic [11:0] a, input logic [11:0] off,
                                   input logic wr);
        wr_at = wr && (a == off);
    endfunction

    assign wr_ctrl = wr_at(REG_ADDR_I, `PDMA_OFF_CTRL, REG_WR_I);
    assign wr_rx_ptr = wr_at(REG_ADDR_I, `PDMA_OFF_RX_PTR, REG_WR_I);
    assign wr_tx_ptr = wr_at(REG_ADDR_I, `PDMA_OFF_TX_PTR, REG_WR_I);
    assign wr_rx_cnt = wr_at(REG_ADDR_I, `PDMA_OFF_RX_CNT, REG_WR_I);
    assign wr_tx_cnt = wr_at(REG_ADDR_I, `PDMA_OFF_TX_CNT, REG_WR_I);
    assign wr_rx_nptr = wr_at(REG_ADDR_I, `PDMA_OFF_RX_NPTR, REG_WR_I);
    assign wr_tx_nptr = wr_at(REG_ADDR_I, `PDMA_OFF_TX_NPTR, REG_WR_I);
    assign wr_rx_ncnt = wr_at(REG_ADDR_I, `PDMA_OFF_RX_NCNT, REG_WR_I);
    assign wr_tx_ncnt = wr_at(REG_ADDR_I, `PDMA_OFF_TX_NCNT, REG_WR_I);

    // in half duplex the transmit copies are ignored and the receive ones serve both
    assign eff_rx_ptr = rx_ptr_q;
    assign eff_tx_ptr = HALF_DUPLEX_I ? rx_ptr_q : tx_ptr_q;
    assign eff_rx_nptr = rx_nptr_q;
    assign eff_tx_nptr = HALF_DUPLEX_I ? rx_nptr_q : tx_nptr_q;
    assign eff_rx_cnt = rx_cnt_q;
    assign eff_tx_cnt = HALF_DUPLEX_I ? rx_cnt_q : tx_cnt_q;
    assign eff_rx_ncnt = rx_ncnt_q;
    assign eff_tx_ncnt = HALF_DUPLEX_I ? rx_ncnt_q : tx_ncnt_q;

    // control decode
    assign rx_en_set = wr_ctrl && REG_WDATA_I[`PDMA_BIT_RX_EN]
                       && !REG_WDATA_I[`PDMA_BIT_RX_DIS];
    assign rx_en_clr = wr_ctrl && (REG_WDATA_I[`PDMA_BIT_RX_DIS]
                       || (HALF_DUPLEX_I && REG_WDATA_I[`PDMA_BIT_TX_DIS]));
    assign tx_en_set = wr_ctrl && REG_WDATA_I[`PDMA_BIT_TX_EN]
                       && !REG_WDATA_I[`PDMA_BIT_TX_DIS]
                       && !(HALF_DUPLEX_I && REG_WDATA_I[`PDMA_BIT_RX_EN]);
    assign tx_en_clr = wr_ctrl && (REG_WDATA_I[`PDMA_BIT_TX_DIS]
                       || (HALF_DUPLEX_I && (rx_en_set || REG_WDATA_I[`PDMA_BIT_RX_DIS])));

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rx_en_q <= 1'b0;
        end else if (rx_en_set) begin
            rx_en_q <= 1'b1;
        end else if (rx_en_clr || (HALF_DUPLEX_I && tx_en_set)) begin
            rx_en_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_en_q <= 1'b0;
        end else if (tx_en_clr) begin
            tx_en_q <= 1'b0;
        end else if (tx_en_set) begin
            tx_en_q <= 1'b1;
        end
    end

    // a transfer may start only while enabled, count nonzero and peripheral ready
    assign rx_go = rx_en_q && (eff_rx_cnt != 16'h0000) && RX_READY_I;
    assign tx_go = tx_en_q && (eff_tx_cnt != 16'h0000) && TX_READY_I;
    assign BUS_REQ_O = (state_q == pdma_pkg::PDMA_IDLE) && (rx_go || tx_go);

    // one item per bus grant; receive has priority when both are ready
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_q <= pdma_pkg::PDMA_IDLE;
            dir_tx_q <= 1'b0;
            addr_q <= `PDMA_RST_PTR;
            data_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                pdma_pkg::PDMA_IDLE: begin
                    if (BUS_REQ_O && BUS_GNT_I) begin
                        dir_tx_q <= !rx_go;
                        addr_q <= rx_go ? eff_rx_ptr : eff_tx_ptr;
                        data_q <= RX_HOLD_DATA_I;
                        state_q <= rx_go ? pdma_pkg::PDMA_WR : pdma_pkg::PDMA_RD;
                    end
                end
                pdma_pkg::PDMA_RD: begin
                    if (BUS_DONE_I) begin
                        data_q <= BUS_RDATA_I;
                        state_q <= pdma_pkg::PDMA_IDLE;
                    end
                end
                pdma_pkg::PDMA_WR: begin
                    if (BUS_DONE_I) begin
                        state_q <= pdma_pkg::PDMA_IDLE;
                    end
                end
                default: state_q <= pdma_pkg::PDMA_IDLE;
            endcase
        end
    end

    assign RX_HOLD_RD_O = (state_q == pdma_pkg::PDMA_IDLE) && BUS_GNT_I && BUS_REQ_O && rx_go;
    assign BUS_ADDR_O = addr_q;
    assign BUS_WR_O = (state_q == pdma_pkg::PDMA_WR);
    assign BUS_WDATA_O = data_q;
    assign step_rx = (state_q == pdma_pkg::PDMA_WR) && BUS_DONE_I;
    assign step_tx = (state_q == pdma_pkg::PDMA_RD) && BUS_DONE_I;
    assign step = step_rx || step_tx;

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            TX_HOLD_WR_O <= 1'b0;
            TX_HOLD_DATA_O <= 32'h0000_0000;
        end else begin
            TX_HOLD_WR_O <= step_tx;
            if (step_tx) begin
                TX_HOLD_DATA_O <= BUS_RDATA_I;
            end
        end
    end

    // receive-side storage; it is the shared storage in half duplex
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rx_ptr_q <= `PDMA_RST_PTR;
            rx_cnt_q <= `PDMA_RST_CNT;
            rx_nptr_q <= `PDMA_RST_PTR;
            rx_ncnt_q <= `PDMA_RST_CNT;
        end else begin
            if ((step_rx || (HALF_DUPLEX_I && step_tx)) && !wr_rx_cnt) begin
                if (rx_cnt_q == 16'h0001 && rx_ncnt_q != 16'h0000) begin
                    rx_ptr_q <= rx_nptr_q;
                    rx_cnt_q <= rx_ncnt_q;
                    rx_nptr_q <= `PDMA_RST_PTR;
                    rx_ncnt_q <= `PDMA_RST_CNT;
                end else begin
                    rx_ptr_q <= rx_ptr_q + size_step(XFER_SIZE_I);
                    rx_cnt_q <= rx_cnt_q - 16'h0001;
                end
            end
            // a pointer rewrite mid-buffer simply takes over from the next item
            if (wr_rx_ptr || (HALF_DUPLEX_I && wr_tx_ptr)) begin
                rx_ptr_q <= REG_WDATA_I;
            end
            if (wr_rx_cnt || (HALF_DUPLEX_I && wr_tx_cnt)) begin
                rx_cnt_q <= REG_WDATA_I[15:0];
            end
            if (wr_rx_nptr || (HALF_DUPLEX_I && wr_tx_nptr)) begin
                rx_nptr_q <= REG_WDATA_I;
            end
            if (wr_rx_ncnt || (HALF_DUPLEX_I && wr_tx_ncnt)) begin
                rx_ncnt_q <= REG_WDATA_I[15:0];
            end
        end
    end

    // transmit-side storage, used in full duplex only
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_ptr_q <= `PDMA_RST_PTR;
            tx_cnt_q <= `PDMA_RST_CNT;
            tx_nptr_q <= `PDMA_RST_PTR;
            tx_ncnt_q <= `PDMA_RST_CNT;
        end else begin
            if (step_tx && !HALF_DUPLEX_I && !wr_tx_cnt) begin
                if (tx_cnt_q == 16'h0001 && tx_ncnt_q != 16'h0000) begin
                    tx_ptr_q <= tx_nptr_q;
                    tx_cnt_q <= tx_ncnt_q;
                    tx_nptr_q <= `PDMA_RST_PTR;
                    tx_ncnt_q <= `PDMA_RST_CNT;
                end else begin
                    tx_ptr_q <= tx_ptr_q + size_step(XFER_SIZE_I);
                    tx_cnt_q <= tx_cnt_q - 16'h0001;
                end
            end
            if (wr_tx_ptr) begin
                tx_ptr_q <= REG_WDATA_I;
            end
            if (wr_tx_cnt) begin
                tx_cnt_q <= REG_WDATA_I[15:0];
            end
            if (wr_tx_nptr) begin
                tx_nptr_q <= REG_WDATA_I;
            end
            if (wr_tx_ncnt) begin
                tx_ncnt_q <= REG_WDATA_I[15:0];
            end
        end
    end

    // flags: the reaching-zero event wins over a clearing write in the same cycle
    logic rx_last, tx_last, rx_clr, tx_clr;
    assign rx_last = (step_rx || (HALF_DUPLEX_I && step_tx)) && rx_cnt_q == 16'h0001;
    assign tx_last = step_tx && eff_tx_cnt == 16'h0001;
    assign rx_clr = ((wr_rx_cnt || wr_rx_ncnt) && REG_WDATA_I[15:0] != 16'h0000)
                    || (HALF_DUPLEX_I && (wr_tx_cnt || wr_tx_ncnt)
                    && REG_WDATA_I[15:0] != 16'h0000);
    assign tx_clr = ((wr_tx_cnt || wr_tx_ncnt) && REG_WDATA_I[15:0] != 16'h0000)
                    || (HALF_DUPLEX_I && (wr_rx_cnt || wr_rx_ncnt)
                    && REG_WDATA_I[15:0] != 16'h0000);

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rx_end_q <= 1'b0;
            rx_full_q <= 1'b0;
        end else begin
            if (rx_last && !step_tx) begin
                rx_end_q <= 1'b1;
                rx_full_q <= rx_full_q || (rx_ncnt_q == 16'h0000);
            end else if (rx_clr) begin
                rx_end_q <= 1'b0;
                rx_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_end_q <= 1'b0;
            tx_empty_q <= 1'b0;
        end else begin
            if (tx_last) begin
                tx_end_q <= 1'b1;
                tx_empty_q <= tx_empty_q || (eff_tx_ncnt == 16'h0000);
            end else if (tx_clr) begin
                tx_end_q <= 1'b0;
                tx_empty_q <= 1'b0;
            end
        end
    end

    assign RX_END_FLAG_O = rx_end_q;
    assign RX_BUFFER_FULL_FLAG_O = rx_full_q;
    assign TX_END_FLAG_O = tx_end_q;
    assign TX_BUFFER_EMPTY_FLAG_O = tx_empty_q;

    // read port; control register is write-only and reads as zero
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rdata_q <= 32'h0000_0000;
        end else if (REG_RD_I) begin
            case (REG_ADDR_I)
                `PDMA_OFF_RX_PTR: rdata_q <= eff_rx_ptr;
                `PDMA_OFF_RX_CNT: rdata_q <= {16'h0000, eff_rx_cnt};
                `PDMA_OFF_TX_PTR: rdata_q <= eff_tx_ptr;
                `PDMA_OFF_TX_CNT: rdata_q <= {16'h0000, eff_tx_cnt};
                `PDMA_OFF_RX_NPTR: rdata_q <= eff_rx_nptr;
                `PDMA_OFF_RX_NCNT: rdata_q <= {16'h0000, eff_rx_ncnt};
                `PDMA_OFF_TX_NPTR: rdata_q <= eff_tx_nptr;
                `PDMA_OFF_TX_NCNT: rdata_q <= {16'h0000, eff_tx_ncnt};
                `PDMA_OFF_STAT: rdata_q <= {23'h000000, tx_en_q, 7'h00, rx_en_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign REG_RDATA_O = rdata_q;

    AST_RX_HALT: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        (rx_cnt_q == 16'h0000) |-> !RX_HOLD_RD_O)
        else $error("receive read with zero count");
    AST_TX_HALT: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        (state_q == pdma_pkg::PDMA_IDLE && eff_tx_cnt == 16'h0000 && !rx_go) |-> !BUS_REQ_O)
        else $error("transmit request with zero count");
    AST_HD_SHARE: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        HALF_DUPLEX_I |-> (eff_tx_ptr == eff_rx_ptr && eff_tx_cnt == eff_rx_cnt))
        else $error("half duplex storage diverged");
    AST_RX_EN: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        rx_en_set |=> rx_en_q)
        else $error("receive enable lost");
    AST_RX_DIS: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        (wr_ctrl && REG_WDATA_I[`PDMA_BIT_RX_DIS]) |=> !rx_en_q)
        else $error("receive disable ignored");
    AST_TX_DIS: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        (wr_ctrl && REG_WDATA_I[`PDMA_BIT_TX_DIS]) |=> !tx_en_q)
        else $error("transmit disable ignored");
    AST_HD_EXCL: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        HALF_DUPLEX_I && $past(HALF_DUPLEX_I) && !$past(rx_en_q && tx_en_q)
        |-> !(rx_en_q && tx_en_q))
        else $error("both directions enabled in half duplex");
    AST_STAT: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        (REG_RD_I && REG_ADDR_I == `PDMA_OFF_STAT) |=> REG_RDATA_O[0] == $past(rx_en_q)
        && REG_RDATA_O[8] == $past(tx_en_q))
        else $error("status read wrong");
    AST_REQ: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        BUS_REQ_O |-> (rx_go || tx_go))
        else $error("request without cause");
    AST_END: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        (tx_last && !HALF_DUPLEX_I) |=> TX_END_FLAG_O)
        else $error("transmit end flag missing");
    AST_RELOAD: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        (step_rx && rx_cnt_q == 16'h0001 && rx_ncnt_q != 16'h0000 && !REG_WR_I)
        |=> (rx_cnt_q == $past(rx_ncnt_q) && rx_ncnt_q == 16'h0000))
        else $error("receive reload from next missing");
    AST_TX_STEP: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        (step_tx && !HALF_DUPLEX_I && tx_ncnt_q == 16'h0000 && !REG_WR_I)
        |=> (tx_cnt_q == $past(tx_cnt_q) - 16'h0001
        && tx_ptr_q == $past(tx_ptr_q) + size_step($past(XFER_SIZE_I))))
        else $error("transmit step wrong");
    COV_RX: cover property (@(posedge CLOCK_I) step_rx);
    COV_HD: cover property (@(posedge CLOCK_I) HALF_DUPLEX_I && step_tx);
    COV_TX: cover property (@(posedge CLOCK_I) TX_HOLD_WR_O);
    COV_RELOAD: cover property (@(posedge CLOCK_I) rx_last && rx_ncnt_q != 16'h0000);
endmodule

// ===== verif/pdma_far_side.sv
// serial peripheral and bus matrix model facing the dma channel pair
`timescale 1ns/1ps
module pdma_far_side (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic rx_on_i,
    input wire logic tx_on_i,
    input wire logic [2:0] lat_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    input wire logic hold_rd_i,
    input wire logic [31:0] tx_data_i,
    input wire logic tx_wr_i,
    output logic rx_ready_o,
    output logic tx_ready_o,
    output logic [31:0] rx_data_o,
    output logic gnt_o,
    output logic [31:0] rdata_o,
    output logic done_o
);
    logic busy;
    logic [2:0] wait_q;
    int n_gnt = 0;
    int n_wr = 0;
    logic [31:0] wr_addr, wr_data, tx_last;
    assign rx_ready_o = rx_on_i;
    assign tx_ready_o = tx_on_i;
    assign gnt_o = !busy;
    // outside the done cycle the bus shows the inverted word, so a late sample is caught
    assign rdata_o = done_o ? (addr_i ^ 32'h5a5a_0f0f) : ~(addr_i ^ 32'h5a5a_0f0f);
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy <= 1'b0;
            done_o <= 1'b0;
            wait_q <= 3'h0;
            rx_data_o <= 32'hc0de_0000;
        end else begin
            done_o <= 1'b0;
            if (hold_rd_i) begin
                rx_data_o <= rx_data_o + 32'h1;
            end
            if (req_i && !busy) begin
                busy <= 1'b1;
                wait_q <= lat_i;
                n_gnt <= n_gnt + 1;
            end else if (done_o) begin
                busy <= 1'b0;
            end else if (busy) begin
                if (wait_q == 3'h0) begin
                    done_o <= 1'b1;
                end else begin
                    wait_q <= wait_q - 3'h1;
                end
            end
        end
    end
    always @(posedge clk_i) begin
        if (done_o && wr_i) begin
            n_wr <= n_wr + 1;
            wr_addr <= addr_i;
            wr_data <= wdata_i;
        end
        if (tx_wr_i) begin
            tx_last <= tx_data_i;
        end
    end
endmodule

// ===== verif/tb_pdma_channel_pair.sv
// self-checking bench for the dma channel pair
`timescale 1ns/1ps
`include "pdma_regs.svh"
module tb_pdma_channel_pair;
    logic clk, rstn, half, wr, rd, rx_on, tx_on, rx_rdy, tx_rdy, hold_rd, tx_wr;
    logic req, gnt, bwr, bdone, f_rxe, f_rxf, f_txe, f_txb;
    logic [1:0] xsize;
    logic [2:0] lat;
    logic [11:0] raddr;
    logic [31:0] wdata, rdata, rx_hold, tx_hold, baddr, bwdata, brdata, seed, v, p, q, d0;
    int fails, n_compared, n0;
    localparam logic [31:0] FD_T [7] = '{32'h0101_0101, 32'h0000_0101, 32'h0200_0001,
        32'h0003_0000, 32'h0100_0100, 32'h0003_0100, 32'h0300_0000};
    localparam logic [31:0] HD_T [10] = '{32'h0100_0100, 32'h0001_0001, 32'h0100_0100,
        32'h0200_0000, 32'h0001_0001, 32'h0200_0000, 32'h0001_0001, 32'h0002_0000,
        32'h0100_0100, 32'h0002_0000};

    pdma_channel_pair i_pdma_channel_pair (.CLOCK_I(clk), .RESETN_I(rstn),
        .HALF_DUPLEX_I(half), .XFER_SIZE_I(xsize), .REG_ADDR_I(raddr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .RX_READY_I(rx_rdy),
        .TX_READY_I(tx_rdy), .RX_HOLD_DATA_I(rx_hold), .RX_HOLD_RD_O(hold_rd),
        .TX_HOLD_DATA_O(tx_hold), .TX_HOLD_WR_O(tx_wr), .BUS_REQ_O(req), .BUS_GNT_I(gnt),
        .BUS_ADDR_O(baddr), .BUS_WR_O(bwr), .BUS_WDATA_O(bwdata), .BUS_RDATA_I(brdata),
        .BUS_DONE_I(bdone), .RX_END_FLAG_O(f_rxe), .RX_BUFFER_FULL_FLAG_O(f_rxf),
        .TX_END_FLAG_O(f_txe), .TX_BUFFER_EMPTY_FLAG_O(f_txb));
    pdma_far_side i_pdma_far_side (.clk_i(clk), .rstn_i(rstn), .rx_on_i(rx_on),
        .tx_on_i(tx_on), .lat_i(lat), .req_i(req), .addr_i(baddr), .wr_i(bwr),
        .wdata_i(bwdata), .hold_rd_i(hold_rd), .tx_data_i(tx_hold), .tx_wr_i(tx_wr),
        .rx_ready_o(rx_rdy), .tx_ready_o(tx_rdy), .rx_data_o(rx_hold), .gnt_o(gnt),
        .rdata_o(brdata), .done_o(bdone));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // pointer step per item; the unused size code moves like a byte
    function automatic logic [31:0] exp_step(input logic [1:0] sz);
        if (sz == pdma_pkg::PDMA_SZ_HALF) return 32'h2;
        if (sz == pdma_pkg::PDMA_SZ_WORD) return 32'h4;
        return 32'h1;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        raddr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        raddr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chkreg(input logic [11:0] a, input logic [31:0] exp);
        rreg(a, v);
        chk(v, exp);
    endtask
    task automatic chkflags(input logic [3:0] exp);
        @(posedge clk);
        #1;
        chk({28'h0, f_rxe, f_rxf, f_txe, f_txb}, {28'h0, exp});
    endtask
    task automatic ctl(input logic [31:0] e);
        wreg(`PDMA_OFF_CTRL, {16'h0, e[31:16]});
        chkreg(`PDMA_OFF_STAT, {16'h0, e[15:0]});
    endtask
    task automatic do_reset(input logic h);
        @(posedge clk);
        rstn <= 1'b0;
        half <= h;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500000;
        fails++;
        print_verdict();
    end
    initial begin
        fails = 0;
        n_compared = 0;
        seed = 32'ha3e9;
        {rstn, half, wr, rd, rx_on, tx_on, xsize, lat, raddr, wdata} = '0;
        do_reset(1'b0);
        // the last offset is unmapped and must read zero
        for (int i = 0; i < 11; i++) chkreg(12'h100 + 12'(i * 4), 32'h0);
        for (int i = 0; i < 8; i++) begin
            seed = nxt(seed);
            wreg(12'h100 + 12'(i * 4), seed);
            chkreg(12'h100 + 12'(i * 4), i[0] ? {16'h0, seed[15:0]} : seed);
        end
        wreg(`PDMA_OFF_STAT, 32'hffff_ffff);
        chkreg(`PDMA_OFF_STAT, 32'h0);
        for (int i = 0; i < 7; i++) ctl(FD_T[i]);
        do_reset(1'b0);
        @(posedge clk);
        rx_on <= 1'b1;
        tx_on <= 1'b1;
        wreg(`PDMA_OFF_RX_CNT, 32'h5);
        wreg(`PDMA_OFF_TX_CNT, 32'h5);
        repeat (20) @(posedge clk);
        chk(32'(i_pdma_far_side.n_gnt), 32'h0);
        wreg(`PDMA_OFF_RX_CNT, 32'h0);
        wreg(`PDMA_OFF_TX_CNT, 32'h0);
        wreg(`PDMA_OFF_CTRL, 32'h101);
        repeat (20) @(posedge clk);
        chk(32'(i_pdma_far_side.n_gnt), 32'h0);
        wreg(`PDMA_OFF_CTRL, 32'h202);
        @(posedge clk);
        rx_on <= 1'b0;
        tx_on <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            seed = nxt(seed);
            p = seed;
            seed = nxt(seed);
            q = seed;
            @(posedge clk);
            xsize <= 2'(s);
            lat <= 3'(s * 2);
            n0 = i_pdma_far_side.n_wr;
            d0 = i_pdma_far_side.rx_data_o;
            wreg(`PDMA_OFF_RX_PTR, p);
            wreg(`PDMA_OFF_RX_CNT, 32'h2);
            wreg(`PDMA_OFF_RX_NPTR, q);
            wreg(`PDMA_OFF_RX_NCNT, 32'h1);
            wreg(`PDMA_OFF_CTRL, 32'h1);
            @(posedge clk);
            rx_on <= 1'b1;
            for (int i = 0; i < 400 && f_rxf !== 1'b1; i++) @(posedge clk);
            rx_on <= 1'b0;
            chkflags(4'b1100);
            chkreg(`PDMA_OFF_RX_PTR, q + exp_step(2'(s)));
            chkreg(`PDMA_OFF_RX_CNT, 32'h0);
            chkreg(`PDMA_OFF_RX_NPTR, 32'h0);
            chkreg(`PDMA_OFF_RX_NCNT, 32'h0);
            chk(32'(i_pdma_far_side.n_wr - n0), 32'h3);
            chk(i_pdma_far_side.wr_addr, q);
            chk(i_pdma_far_side.wr_data, d0 + 32'h2);
            wreg(`PDMA_OFF_CTRL, 32'h2);
            wreg(`PDMA_OFF_RX_NCNT, 32'h3);
            chkflags(4'b0000);
        end
        seed = nxt(seed);
        p = seed;
        @(posedge clk);
        xsize <= 2'h2;
        lat <= 3'h5;
        wreg(`PDMA_OFF_TX_PTR, p);
        wreg(`PDMA_OFF_TX_CNT, 32'h1);
        wreg(`PDMA_OFF_TX_NCNT, 32'h0);
        wreg(`PDMA_OFF_CTRL, 32'h100);
        @(posedge clk);
        tx_on <= 1'b1;
        for (int i = 0; i < 400 && f_txb !== 1'b1; i++) @(posedge clk);
        tx_on <= 1'b0;
        chkflags(4'b0011);
        chk(i_pdma_far_side.tx_last, p ^ 32'h5a5a_0f0f);
        chkreg(`PDMA_OFF_TX_PTR, p + 32'h4);
        chkreg(`PDMA_OFF_TX_CNT, 32'h0);
        wreg(`PDMA_OFF_TX_CNT, 32'h2);
        chkflags(4'b0000);
        do_reset(1'b1);
        seed = nxt(seed);
        wreg(`PDMA_OFF_TX_PTR, seed);
        chkreg(`PDMA_OFF_RX_PTR, seed);
        wreg(`PDMA_OFF_RX_NPTR, ~seed);
        chkreg(`PDMA_OFF_TX_NPTR, ~seed);
        wreg(`PDMA_OFF_RX_CNT, seed);
        chkreg(`PDMA_OFF_TX_CNT, {16'h0, seed[15:0]});
        wreg(`PDMA_OFF_TX_NCNT, ~seed);
        chkreg(`PDMA_OFF_RX_NCNT, {16'h0, ~seed[15:0]});
        // both enables together are never written in shared mode
        for (int i = 0; i < 10; i++) ctl(HD_T[i]);
        // one transmit item over the shared channel, count loaded through the transmit offset and next count through the receive one
        wreg(`PDMA_OFF_TX_CNT, 32'h1);
        wreg(`PDMA_OFF_RX_NCNT, 32'h0);
        wreg(`PDMA_OFF_CTRL, 32'h100);
        @(posedge clk);
        tx_on <= 1'b1;
        for (int i = 0; i < 400 && f_txb !== 1'b1; i++) @(posedge clk);
        tx_on <= 1'b0;
        chkflags(4'b0011);
        chk(i_pdma_far_side.tx_last, seed ^ 32'h5a5a_0f0f);
        chkreg(`PDMA_OFF_RX_PTR, seed + 32'h4);
        chkreg(`PDMA_OFF_RX_CNT, 32'h0);
        print_verdict();
    end
endmodule
